// file: acop_assertions.sv
module acop_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic convert_start_n,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic format_select,
  input wire logic power_down_n,
  input wire logic busy,
  input wire logic [acop_pkg::RES_W-1:0] par_data_oe_n,
  input wire logic serial_data_oe_n,
  input wire logic conv_clock_output
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic ck_d;
  logic [5:0] ck_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // Counts mirrored clock rises per conversion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_d <= 1'b0;
      ck_cnt <= 6'h00;
    end else begin
      ck_d <= conv_clock_output;
      if ($fell(busy))
        ck_cnt <= 6'h00;
      else if (conv_clock_output && !ck_d)
        ck_cnt <= ck_cnt + 6'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  start_busy_a: assert property ($fell(convert_start_n) && !chip_select_n && power_down_n
    && busy |-> ##[1:8] !busy) else $error("start not taken");
  busy_min_a: assert property ($fell(busy) |-> !busy [*8]) else $error("busy too short");
  busy_end_a: assert property ($fell(busy) |-> ##[1:600] busy) else $error("no end");
  conv_count_a: assert property ($rose(busy) && ck_cnt != 6'h00 |-> ck_cnt == 6'h10)
    else $error("wrong clock count");
  // Four cycles allow for the input synchronisers
  par_float_a: assert property ((chip_select_n || read_strobe_n) [*4] |-> &par_data_oe_n)
    else $error("parallel pins driven");
  ser_float_a: assert property ((chip_select_n || read_strobe_n) [*4] |-> serial_data_oe_n)
    else $error("serial pin driven");
  pin_float_a: assert property (format_select [*4] |-> &par_data_oe_n[13:5])
    else $error("parallel-only pin driven");
  clk_idle_a: assert property (busy [*4] |-> !conv_clock_output)
    else $error("clock out not idle");
endmodule

// file: acop_device.sv
// What this block does
// - Start converting on start fall with select low
// - Ignore start requests while converting
// - Busy low during conversion, high otherwise
// - Parallel format: 14-bit word updated per conversion
// - Serial format: parallel-only pins float
// - Drive data outputs only when select and read low
// - Unipolar straight binary, bipolar two's complement
// - Read-strobed mode: float until read asserted
// - Slow memory: old result, new after busy
// - ROM mode: strobe starts and reads previous
// - Load shift register and raise busy on the same edge
// - Internal oscillator gives exactly 16 cycles
// - External clock gated to 16 cycles
// - External conversion clock 30kHz to 4.5MHz
// - Mirror conversion clock on output during a conversion while select and read low, else low
// - 16-bit shift, 14 bits MSB first, two zeros
// - Reader supplies at least 14 shift clocks
// - Read high blocks shift clock, floats data
// - Select high floats data, blocks starts
// - Power down: sleep if deselected, else nap
// - Data advances on each shift clock fall
// - Reader may sample either edge, rising preferred
// - Extra shift clocks give zeros forever
module acop_device (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  acop_if.device pins,
  input wire logic [acop_pkg::RES_W-1:0] analog_code,
  input wire logic bipolar_mode,
  output logic nap,
  output logic sleep
);
  ////////////////////////////////////////////////////////////////////////
  logic [acop_pkg::PIN_W-1:0] pin_s;
  logic convert_start_n_s;
  logic cs_s;
  logic rd_s;
  logic fmt_s;
  logic src_s;
  logic ext_s;
  logic sclk_s;
  logic pdn_s;
  logic convert_start_n_prev;
  logic sclk_prev;
  logic cclk_prev;
  acop_pkg::acop_dev_state_t state_reg;
  logic [4:0] edge_cnt_reg;
  logic [3:0] osc_cnt_reg;
  logic osc_reg;
  logic conv_lvl;
  logic cclk_rise;
  logic cclk_fall;
  logic start;
  logic finish;
  logic sel_rd;
  logic [acop_pkg::RES_W-1:0] hold_reg;
  logic [acop_pkg::RES_W-1:0] code_next;
  logic [acop_pkg::RES_W-1:0] result_reg;
  logic [acop_pkg::SREG_W-1:0] sreg_reg;
  logic busy_reg;
  logic [acop_pkg::RES_W-1:0] par_oe_n_reg;
  logic sdo_oe_n_reg;
  logic conv_clock_output_reg;
  logic conv_clock_output_oe_n_reg;

  acop_sync #(
    .W(acop_pkg::PIN_W)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .d({pins.convert_start_n, pins.chip_select_n, pins.read_strobe_n,
        pins.format_select, pins.conv_clock_source, pins.ext_conv_clock_in,
        pins.shift_clock, pins.power_down_n}),
    .q(pin_s)
  );

  assign convert_start_n_s = pin_s[7];
  assign cs_s = pin_s[6];
  assign rd_s = pin_s[5];
  assign fmt_s = pin_s[4];
  assign src_s = pin_s[3];
  assign ext_s = pin_s[2];
  assign sclk_s = pin_s[1];
  assign pdn_s = pin_s[0];

  ////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      convert_start_n_prev <= 1'b1;
      sclk_prev <= 1'b0;
      cclk_prev <= 1'b0;
    end else if (ce) begin
      convert_start_n_prev <= convert_start_n_s;
      sclk_prev <= sclk_s;
      cclk_prev <= conv_lvl;
    end
  end

  assign conv_lvl = src_s ? ext_s : osc_reg;
  assign cclk_rise = conv_lvl & ~cclk_prev;
  assign cclk_fall = ~conv_lvl & cclk_prev;
  assign sel_rd = ~cs_s & ~rd_s;
  // Shutdown also blocks starts
  assign start = (state_reg == acop_pkg::DEV_IDLE) && convert_start_n_prev && !convert_start_n_s &&
                 !cs_s && pdn_s;
  // Ends on the falling edge after the 16th rising one
  assign finish = (state_reg == acop_pkg::DEV_CONV) && cclk_fall &&
                  (edge_cnt_reg == 5'(acop_pkg::CONV_CYCLES));
  assign code_next = bipolar_mode ? {~hold_reg[acop_pkg::RES_W-1],
                     hold_reg[acop_pkg::RES_W-2:0]} : hold_reg;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= acop_pkg::DEV_IDLE;
    end else if (ce) begin
      case (state_reg)
        acop_pkg::DEV_IDLE: begin
          if (start) begin
            state_reg <= acop_pkg::DEV_CONV;
          end
        end
        acop_pkg::DEV_CONV: begin
          if (finish) begin
            state_reg <= acop_pkg::DEV_IDLE;
          end
        end
        default: begin
          state_reg <= acop_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // Oscillator runs only inside a conversion, so no stray cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_reg <= 1'b0;
      osc_cnt_reg <= 4'h0;
    end else if (ce) begin
      if (state_reg != acop_pkg::DEV_CONV || start) begin
        osc_reg <= 1'b0;
        osc_cnt_reg <= 4'h0;
      end else if (osc_cnt_reg == 4'(acop_pkg::OSC_HALF_CYC - 1)) begin
        osc_reg <= ~osc_reg;
        osc_cnt_reg <= 4'h0;
      end else begin
        osc_cnt_reg <= osc_cnt_reg + 4'h1;
      end
    end
  end

  // Edges past 16 are not counted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_cnt_reg <= 5'h00;
    end else if (ce) begin
      if (start) begin
        edge_cnt_reg <= 5'h00;
      end else if (state_reg == acop_pkg::DEV_CONV && cclk_rise &&
                   edge_cnt_reg < 5'(acop_pkg::CONV_CYCLES)) begin
        edge_cnt_reg <= edge_cnt_reg + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample held at start, result latched at the end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_reg <= '0;
      result_reg <= '0;
    end else if (ce) begin
      if (start) begin
        hold_reg <= analog_code;
      end
      if (finish) begin
        result_reg <= code_next;
      end
    end
  end

  // Load wins over a shift in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sreg_reg <= '0;
    end else if (ce) begin
      if (finish) begin
        sreg_reg <= {code_next, 2'b00};
      end else if (fmt_s && sel_rd && sclk_prev && !sclk_s) begin
        sreg_reg <= {sreg_reg[acop_pkg::SREG_W-2:0], 1'b0};
      end
    end
  end

  // Busy rises in the same edge as the load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_reg <= 1'b1;
    end else if (ce) begin
      if (start) begin
        busy_reg <= 1'b0;
      end else if (finish) begin
        busy_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output enables, registered so pins come from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      par_oe_n_reg <= '1;
      sdo_oe_n_reg <= 1'b1;
      conv_clock_output_oe_n_reg <= 1'b1;
    end else if (ce) begin
      par_oe_n_reg <= {acop_pkg::RES_W{~(~fmt_s & sel_rd)}};
      sdo_oe_n_reg <= ~(fmt_s & sel_rd);
      conv_clock_output_oe_n_reg <= ~fmt_s;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_clock_output_reg <= 1'b0;
    end else if (ce) begin
      // Only pulses whose rise fell inside the gate, so a high clock at start is not mirrored
      conv_clock_output_reg <= (state_reg == acop_pkg::DEV_CONV) && sel_rd && conv_lvl && !finish &&
                    (cclk_rise ? (edge_cnt_reg < 5'(acop_pkg::CONV_CYCLES)) :
                    conv_clock_output_reg);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nap <= 1'b0;
      sleep <= 1'b0;
    end else if (ce) begin
      nap <= ~pdn_s & ~cs_s;
      sleep <= ~pdn_s & cs_s;
    end
  end

  assign pins.busy = busy_reg;
  assign pins.par_data_o = result_reg;
  assign pins.par_data_oe_n = par_oe_n_reg;
  assign pins.serial_data_out = sreg_reg[acop_pkg::SREG_W-1];
  assign pins.serial_data_oe_n = sdo_oe_n_reg;
  assign pins.conv_clock_output = conv_clock_output_reg;
  assign pins.conv_clock_oe_n = conv_clock_output_oe_n_reg;
endmodule

// file: acop_host.sv
// Implementation choices: the register offsets and the AHB-Lite slave port.
module acop_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  acop_if.host pins
);
  ////////////////////////////////////////////////////////////////////////
  logic [15:0] in_s;
  logic busy_s;
  logic sdo_s;
  logic [acop_pkg::RES_W-1:0] par_s;
  logic addr_ok;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [acop_pkg::CTRL_W-1:0] ctrl_reg;
  logic done_reg;
  logic done_set;
  logic cmd_go;
  logic [acop_pkg::RES_W-1:0] data_reg;
  logic [acop_pkg::RES_W-1:0] prev_reg;
  acop_pkg::acop_host_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [5:0] bit_reg;
  logic half_end;
  logic sample;
  logic capture;
  logic [acop_pkg::RES_W-1:0] capture_val;
  logic [acop_pkg::SREG_W-1:0] shift_reg;
  logic [31:0] rd_mux;
  logic convert_start_n_n_reg;
  logic rd_n_reg;
  logic sclk_reg;
  logic ext_reg;
  logic [4:0] ext_cnt_reg;

  acop_sync #(
    .W(acop_pkg::RES_W + 2)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .d({pins.busy, pins.serial_data_bus, pins.par_data_bus}),
    .q(in_s)
  );

  assign busy_s = in_s[15];
  assign sdo_s = in_s[14];
  assign par_s = in_s[acop_pkg::RES_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Zero wait states, so the bus never stalls on the converter
  assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2);
  assign cmd_go = wr_pend_reg && (wr_addr_reg == acop_pkg::CMD_OFF) &&
                  hwdata[acop_pkg::CMD_GO];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (ce && hready) begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= acop_pkg::CTRL_RST;
    end else if (ce) begin
      if (wr_pend_reg && wr_addr_reg == acop_pkg::CTRL_OFF) begin
        ctrl_reg <= hwdata[acop_pkg::CTRL_W-1:0];
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    if (haddr[7:0] == acop_pkg::CTRL_OFF) begin
      rd_mux = {27'h0, ctrl_reg};
    end else if (haddr[7:0] == acop_pkg::STAT_OFF) begin
      rd_mux[acop_pkg::STAT_RUN] = (state_reg != acop_pkg::H_IDLE);
      rd_mux[acop_pkg::STAT_DONE] = done_reg;
    end else if (haddr[7:0] == acop_pkg::DATA_OFF) begin
      rd_mux = {18'h0, data_reg};
    end else if (haddr[7:0] == acop_pkg::PREV_OFF) begin
      rd_mux = {18'h0, prev_reg};
    end
  end

  // Loaded in the address phase, stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (ce) begin
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // First half period is a settle time for enables through both synchronisers
  assign half_end = cnt_reg == ((bit_reg == 6'h00) ? 4'(acop_pkg::SETTLE_CYC - 1) :
                    4'(acop_pkg::SCLK_HALF_CYC - 1));
  // Sampled late in the high phase for hold margin
  assign sample = (state_reg == acop_pkg::H_SHIFT) && half_end && sclk_reg;
  assign capture = ((state_reg == acop_pkg::H_READ) &&
                   (cnt_reg == 4'(acop_pkg::SETTLE_CYC - 1))) ||
                   (sample && bit_reg == 6'(2 * acop_pkg::SREG_W - 1));
  assign capture_val = (state_reg == acop_pkg::H_READ) ? par_s :
                       shift_reg[acop_pkg::SREG_W-2:acop_pkg::SREG_W-1-acop_pkg::RES_W];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= acop_pkg::H_IDLE;
      cnt_reg <= 4'h0;
      bit_reg <= 6'h00;
      sclk_reg <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        acop_pkg::H_IDLE: begin
          cnt_reg <= 4'h0;
          if (cmd_go) begin
            state_reg <= acop_pkg::H_STROBE;
          end
        end
        acop_pkg::H_STROBE: begin
          if (cnt_reg == 4'(acop_pkg::STROBE_CYC - 1)) begin
            state_reg <= acop_pkg::H_WAIT_LO;
            cnt_reg <= 4'h0;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        acop_pkg::H_WAIT_LO: begin
          if (!busy_s) begin
            state_reg <= acop_pkg::H_WAIT_HI;
          end
        end
        acop_pkg::H_WAIT_HI: begin
          if (busy_s) begin
            state_reg <= ctrl_reg[acop_pkg::CTRL_FMT] ? acop_pkg::H_SHIFT : acop_pkg::H_READ;
            cnt_reg <= 4'h0;
            bit_reg <= 6'h00;
          end
        end
        acop_pkg::H_READ: begin
          if (cnt_reg == 4'(acop_pkg::SETTLE_CYC - 1)) begin
            state_reg <= acop_pkg::H_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        acop_pkg::H_SHIFT: begin
          if (half_end) begin
            cnt_reg <= 4'h0;
            bit_reg <= bit_reg + 6'h01;
            sclk_reg <= ~sclk_reg;
            if (bit_reg == 6'(2 * acop_pkg::SREG_W - 1)) begin
              state_reg <= acop_pkg::H_IDLE;
            end
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        default: begin
          state_reg <= acop_pkg::H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_reg <= '0;
    end else if (ce) begin
      if (sample) begin
        shift_reg <= {shift_reg[acop_pkg::SREG_W-2:0], sdo_s};
      end
    end
  end

  // A finished read beats a new go in the same cycle
  assign done_set = capture;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_reg <= '0;
      prev_reg <= '0;
      done_reg <= 1'b0;
    end else if (ce) begin
      if (capture) begin
        prev_reg <= data_reg;
        data_reg <= capture_val;
      end
      if (done_set) begin
        done_reg <= 1'b1;
      end else if (cmd_go) begin
        done_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial mode keeps read low through the conversion so the clock is mirrored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      convert_start_n_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
    end else if (ce) begin
      convert_start_n_n_reg <= ~(state_reg == acop_pkg::H_STROBE);
      rd_n_reg <= ~((state_reg == acop_pkg::H_READ) || (state_reg == acop_pkg::H_SHIFT) ||
                  (ctrl_reg[acop_pkg::CTRL_FMT] && state_reg != acop_pkg::H_IDLE) ||
                  (ctrl_reg[acop_pkg::CTRL_TIED] &&
                  state_reg == acop_pkg::H_STROBE));
    end
  end

  // Free-running; the converter gates it to sixteen cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_reg <= 1'b0;
      ext_cnt_reg <= 5'h00;
    end else if (ce) begin
      if (!ctrl_reg[acop_pkg::CTRL_SRC]) begin
        ext_reg <= 1'b0;
        ext_cnt_reg <= 5'h00;
      end else if (ext_cnt_reg == 5'(acop_pkg::EXT_HALF_CYC - 1)) begin
        ext_reg <= ~ext_reg;
        ext_cnt_reg <= 5'h00;
      end else begin
        ext_cnt_reg <= ext_cnt_reg + 5'h01;
      end
    end
  end

  assign pins.convert_start_n = convert_start_n_n_reg;
  assign pins.chip_select_n = ~ctrl_reg[acop_pkg::CTRL_PDN] & ~ctrl_reg[acop_pkg::CTRL_NAP];
  assign pins.read_strobe_n = rd_n_reg;
  assign pins.format_select = ctrl_reg[acop_pkg::CTRL_FMT];
  assign pins.conv_clock_source = ctrl_reg[acop_pkg::CTRL_SRC];
  assign pins.ext_conv_clock_in = ext_reg;
  assign pins.shift_clock = sclk_reg;
  assign pins.power_down_n = ctrl_reg[acop_pkg::CTRL_PDN];
endmodule

// file: acop_if.sv
interface acop_if;
  logic convert_start_n;
  logic chip_select_n;
  logic read_strobe_n;
  logic format_select;
  logic conv_clock_source;
  logic ext_conv_clock_in;
  logic shift_clock;
  logic power_down_n;
  logic busy;
  logic [acop_pkg::RES_W-1:0] par_data_o;
  logic [acop_pkg::RES_W-1:0] par_data_oe_n;
  logic serial_data_out;
  logic serial_data_oe_n;
  logic conv_clock_output;
  logic conv_clock_oe_n;
  logic [acop_pkg::RES_W-1:0] par_data_bus;
  logic serial_data_bus;

  // Floating lines read as pulled high
  assign par_data_bus = par_data_o | par_data_oe_n;
  assign serial_data_bus = serial_data_out | serial_data_oe_n;

  modport device(
    input convert_start_n, chip_select_n, read_strobe_n, format_select,
    input conv_clock_source, ext_conv_clock_in, shift_clock, power_down_n,
    output busy, par_data_o, par_data_oe_n, serial_data_out,
    output serial_data_oe_n, conv_clock_output, conv_clock_oe_n
  );
  modport host(
    output convert_start_n, chip_select_n, read_strobe_n, format_select,
    output conv_clock_source, ext_conv_clock_in, shift_clock, power_down_n,
    input busy, par_data_bus, serial_data_bus, conv_clock_output, conv_clock_oe_n
  );
endinterface

// file: acop_pkg.sv
package acop_pkg;
  localparam int CLK_NS = 10;
  localparam int RES_W = 14;
  localparam int SREG_W = 16;
  localparam int CONV_CYCLES = 16;
  localparam int OSC_PERIOD_NS = 200;
  localparam int OSC_HALF_CYC = (OSC_PERIOD_NS / CLK_NS) / 2;
  localparam int EXT_PERIOD_NS = 240;
  localparam int EXT_HALF_CYC = (EXT_PERIOD_NS / CLK_NS) / 2;
  localparam int SCLK_PERIOD_NS = 80;
  localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS / CLK_NS) / 2;
  localparam int STROBE_NS = 60;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = 2 * SCLK_HALF_CYC;
  localparam int PIN_W = 8;

  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] CMD_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] DATA_OFF = 8'h0C;
  localparam logic [7:0] PREV_OFF = 8'h10;

  localparam int CTRL_W = 5;
  localparam int CTRL_FMT = 0;
  localparam int CTRL_SRC = 1;
  localparam int CTRL_PDN = 2;
  localparam int CTRL_NAP = 3;
  localparam int CTRL_TIED = 4;
  localparam logic [4:0] CTRL_RST = 5'h04;
  localparam int CMD_GO = 0;
  localparam int STAT_RUN = 0;
  localparam int STAT_DONE = 1;

  typedef enum logic [0:0] {DEV_IDLE, DEV_CONV} acop_dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE, H_STROBE, H_WAIT_LO, H_WAIT_HI, H_READ, H_SHIFT
  } acop_host_state_t;
endpackage

// file: acop_sync.sv
module acop_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '0;
      q <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// file: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [acop_pkg::RES_W-1:0] code = 14'h0;
  logic [31:0] rd_val = 32'h0;
  logic rd_flag = 1'b0;
  logic bip = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] modes [3] = '{32'h04, 32'h05, 32'h07};
  int n_errors = 0;
  int samples_checked = 0;
  acop_if pins_bus();
  always #5 hclk = ~hclk;
  acop_device acop_device_inst(.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .pins(pins_bus),
    .analog_code(code), .bipolar_mode(bip), .nap(), .sleep());
  acop_host acop_host_inst(.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pins(pins_bus));
  acop_assertions acop_assertions_inst(.hclk(hclk), .hresetn(hresetn),
    .convert_start_n(pins_bus.convert_start_n), .chip_select_n(pins_bus.chip_select_n),
    .read_strobe_n(pins_bus.read_strobe_n), .format_select(pins_bus.format_select),
    .power_down_n(pins_bus.power_down_n), .busy(pins_bus.busy),
    .par_data_oe_n(pins_bus.par_data_oe_n), .serial_data_oe_n(pins_bus.serial_data_oe_n),
    .conv_clock_output(pins_bus.conv_clock_output));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  // Bipolar results flip the sign bit of the straight code
  function automatic logic [31:0] enc(input logic [13:0] c);
    return {18'h0, bip ? {~c[13], c[12:0]} : c};
  endfunction
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Single word transfer; waits on hready with no assumed latency
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, r);
    rd_val <= r;
    rd_flag <= 1'b1;
    @(posedge hclk);
    rd_flag <= 1'b0;
  endtask
  // Code held steady so the sampled value is known
  task automatic convert(input logic [13:0] c);
    logic [31:0] s;
    code <= c;
    bus(1'b1, acop_pkg::CMD_OFF, 32'h1, s);
    s = 32'h0;
    for (int i = 0; i < 400 && !(s[acop_pkg::STAT_DONE] === 1'b1
         && s[acop_pkg::STAT_RUN] === 1'b0); i++)
      bus(1'b0, acop_pkg::STAT_OFF, 32'h0, s);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    if (rd_flag === 1'b1 && exp_q.size() > 0)
      check(rd_val, exp_q.pop_front());
  end
  initial begin
    #500us;
    n_errors++;
    wrap_up();
  end
  initial begin
    logic [13:0] a;
    logic [13:0] b;
    logic [31:0] s;
    void'($urandom(32'h13F7));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    expect_rd(acop_pkg::CTRL_OFF, {27'h0, acop_pkg::CTRL_RST});
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, acop_pkg::CTRL_OFF, modes[m], s);
      expect_rd(acop_pkg::CTRL_OFF, modes[m]);
      bip <= (m == 2);
      a = 14'($urandom);
      convert(a);
      expect_rd(acop_pkg::DATA_OFF, enc(a));
      for (int k = 0; k < 2; k++) begin
        b = 14'($urandom);
        convert(b);
        expect_rd(acop_pkg::DATA_OFF, enc(b));
        expect_rd(acop_pkg::PREV_OFF, enc(a));
        a = b;
      end
    end
    // Unmapped place reads as zero
    expect_rd(8'h20, 32'h0);
    wrap_up();
  end
endmodule
